// File: inc/logic_cell_pkg.sv
// Purpose: Shared constants and types for the logic cell front end
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: Select codes, register offsets and reset values live here
package logic_cell_pkg;

  localparam int unsigned NUM_CANDIDATES = 40;
  localparam int unsigned NUM_DATA = 4;
  localparam int unsigned SEL_WIDTH = 6;
  localparam int unsigned GATE_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_SEL0 = 8'h00;
  localparam logic [7:0] OFS_SEL1 = 8'h04;
  localparam logic [7:0] OFS_SEL2 = 8'h08;
  localparam logic [7:0] OFS_SEL3 = 8'h0C;
  localparam logic [7:0] OFS_GATE1 = 8'h10;
  localparam logic [7:0] OFS_GATE2 = 8'h14;
  localparam logic [7:0] OFS_GATE3 = 8'h18;
  localparam logic [7:0] OFS_GATE4 = 8'h1C;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // Control register fields
  localparam int unsigned CTRL_FUNC_LSB = 0;
  localparam int unsigned CTRL_POL_BIT = 4;
  localparam int unsigned CTRL_EN_BIT = 7;

  // Status register fields
  localparam int unsigned STAT_DATA_LSB = 0;
  localparam int unsigned STAT_GATE_LSB = 4;
  localparam int unsigned STAT_OUT_BIT = 8;

  // Reset values
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [1:0] FUNC_RESET = 2'h0;
  localparam logic POL_RESET = 1'b0;
  localparam logic EN_RESET = 1'b0;

  // Select codes
  localparam logic [5:0] CODE_PIN0 = 6'h00;
  localparam logic [5:0] CODE_PIN3 = 6'h03;
  localparam logic [5:0] CODE_SYSCLK = 6'h04;
  localparam logic [5:0] CODE_REFCLK = 6'h0B;
  localparam logic [5:0] CODE_TMR0_OVF = 6'h0C;
  localparam logic [5:0] CODE_TMR2_OVF = 6'h0E;
  localparam logic [5:0] CODE_CAPTURE_COMPARE_ONE = 6'h0F;
  localparam logic [5:0] CODE_NCO = 6'h15;
  localparam logic [5:0] CODE_CMP1 = 6'h16;
  localparam logic [5:0] CODE_PINCHG = 6'h19;
  localparam logic [5:0] CODE_CELL1 = 6'h1A;
  localparam logic [5:0] CODE_CELL4 = 6'h1D;
  localparam logic [5:0] CODE_SER1_DT = 6'h1E;
  localparam logic [5:0] CODE_SSP_SCK = 6'h23;
  localparam logic [5:0] CODE_RSV_LO = 6'h24;
  localparam logic [5:0] CODE_RSV_HI = 6'h25;
  localparam logic [5:0] CODE_WG_A = 6'h26;
  localparam logic [5:0] CODE_WG_B = 6'h27;
  localparam logic [5:0] CODE_FIRST_RSV = 6'h28;

  typedef enum logic [1:0] {
    FUNC_AND_OR,
    FUNC_OR_XOR,
    FUNC_AND4,
    FUNC_OR4
  } func_t;

  typedef struct packed {
    logic enable;
    logic invert;
    func_t func;
    logic [NUM_DATA-1:0][SEL_WIDTH-1:0] sel;
    logic [NUM_DATA-1:0][GATE_WIDTH-1:0] gate;
  } cell_cfg_t;

  typedef struct packed {
    logic [NUM_DATA-1:0] data;
    logic [NUM_DATA-1:0] gate;
    logic out;
  } cell_state_t;

endpackage

// File: verilog/sync_bank.sv
// Purpose: Two-stage synchroniser for a bus of independent levels
// Assumes: Each bit is a level; no multi-bit coherence
// Notes: Stage one is only read by stage two
`timescale 1ns/1ns
module sync_bank #(
  parameter int unsigned WIDTH = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      q <= '0;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule // sync_bank

// File: verilog/logic_cell.sv
// Purpose: Input selection, data gating, function and polarity of one logic cell
// Assumes: APB register access on pclk; candidates arrive asynchronously
// Notes: Gate enables have no reset so they survive every reset but power-on
`timescale 1ns/1ns
module logic_cell
  import logic_cell_pkg::*;
#(
  parameter int unsigned CANDIDATES = NUM_CANDIDATES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CANDIDATES-1:0] candidates,
  output logic [NUM_DATA-1:0] data_in,
  output logic [NUM_DATA-1:0] gate_out,
  output logic cell_out
);

  if (CANDIDATES != NUM_CANDIDATES)
  begin : g_bad_width
    $error("logic_cell: candidate count must be forty");
  end

  // Every candidate must be reachable by a code of the select field
  if ((1 << SEL_WIDTH) < CANDIDATES)
  begin : g_bad_sel
    $error("logic_cell: select field too narrow for the candidates");
  end

  // Gate registers carry a true and an inverted enable per input
  if (GATE_WIDTH != 2 * NUM_DATA)
  begin : g_bad_gate
    $error("logic_cell: gate register width must be twice the input count");
  end

  cell_cfg_t cfg;
  logic [NUM_DATA-1:0][SEL_WIDTH-1:0] sel_bank;
  logic [NUM_DATA-1:0][GATE_WIDTH-1:0] gate_bank;
  func_t func_sel;
  logic polarity_flip;
  logic cell_enable;
  logic lane0_wr;
  logic [CANDIDATES-1:0] cand_sync;
  logic access;
  logic wr_en;
  logic [7:0] offset;
  logic mapped;
  logic [31:0] next_prdata;
  logic [NUM_DATA-1:0] next_data;
  logic [NUM_DATA-1:0] next_gate;
  logic next_out;

  // Candidates cross from other clocks and pins
  sync_bank #(
    .WIDTH(CANDIDATES)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(candidates),
    .q(cand_sync)
  );

  // Mux for one select field; reserved codes give zero
  function automatic logic pick(input logic [CANDIDATES-1:0] c, input logic [5:0] code);
    logic r;
    r = 1'b0;
    if (code >= CODE_FIRST_RSV)
    begin
      r = 1'b0;
    end
    else if (code == CODE_RSV_LO || code == CODE_RSV_HI)
    begin
      r = 1'b0;
    end
    else
    begin
      // Candidate bit index equals the code
      r = c[code];
    end
    return r;
  endfunction

  // OR of enabled true and inverted terms
  function automatic logic gate_or(input logic [NUM_DATA-1:0] d, input logic [7:0] en);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_DATA; i++)
    begin
      r = r | (en[2*i+1] & d[i]);
      r = r | (en[2*i] & ~d[i]);
    end
    return r;
  endfunction

  // Word decode shared by the select and gate banks
  function automatic logic slot_hit(input logic [7:0] ofs, input logic [7:0] base,
    input int idx);
    return ofs == base + 8'(4 * idx);
  endfunction

  // Combining function over the four gate outputs
  function automatic logic combine(input logic [NUM_DATA-1:0] g, input func_t f);
    logic r;
    r = 1'b0;
    case (f)
      FUNC_AND_OR: r = (g[0] & g[1]) | (g[2] & g[3]);
      FUNC_OR_XOR: r = (g[0] | g[1]) ^ (g[2] | g[3]);
      FUNC_AND4: r = &g;
      FUNC_OR4: r = |g;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Writes land on the access edge, when ready is seen high
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite;
  // Writable registers are at most eight bits wide, so only byte lane zero counts
  assign lane0_wr = wr_en & pstrb[0];
  assign offset = paddr[7:0];

  always_comb
  begin
    mapped = (paddr[31:8] == 24'h000000) && (offset[1:0] == 2'h0)
      && (offset <= OFS_STATUS);
  end

  // Zero-wait slave: ready in the access cycle, low otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // Select registers take effect on the next mux update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_DATA; i++)
      begin
        sel_bank[i] <= SEL_RESET;
      end
    end
    else if (lane0_wr)
    begin
      for (int i = 0; i < NUM_DATA; i++)
      begin
        if (slot_hit(offset, OFS_SEL0, i))
        begin
          sel_bank[i] <= pwdata[SEL_WIDTH-1:0];
        end
      end
    end
  end

  // Gate enables: no reset, so only power-on leaves them unknown
  always_ff @(posedge pclk)
  begin
    if (lane0_wr)
    begin
      for (int i = 0; i < NUM_DATA; i++)
      begin
        if (slot_hit(offset, OFS_GATE1, i))
        begin
          gate_bank[i] <= pwdata[GATE_WIDTH-1:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_sel <= func_t'(FUNC_RESET);
      polarity_flip <= POL_RESET;
      cell_enable <= EN_RESET;
    end
    else if (lane0_wr && offset == OFS_CTRL)
    begin
      func_sel <= func_t'(pwdata[CTRL_FUNC_LSB +: 2]);
      polarity_flip <= pwdata[CTRL_POL_BIT];
      cell_enable <= pwdata[CTRL_EN_BIT];
    end
  end

  // One writer per bank; the struct only carries them onward
  always_comb
  begin
    cfg.enable = cell_enable;
    cfg.invert = polarity_flip;
    cfg.func = func_sel;
    cfg.sel = sel_bank;
    cfg.gate = gate_bank;
  end

  // Read mux
  always_comb
  begin
    next_prdata = 32'h00000000;
    case (offset)
      OFS_SEL0: next_prdata[SEL_WIDTH-1:0] = cfg.sel[0];
      OFS_SEL1: next_prdata[SEL_WIDTH-1:0] = cfg.sel[1];
      OFS_SEL2: next_prdata[SEL_WIDTH-1:0] = cfg.sel[2];
      OFS_SEL3: next_prdata[SEL_WIDTH-1:0] = cfg.sel[3];
      OFS_GATE1: next_prdata[GATE_WIDTH-1:0] = cfg.gate[0];
      OFS_GATE2: next_prdata[GATE_WIDTH-1:0] = cfg.gate[1];
      OFS_GATE3: next_prdata[GATE_WIDTH-1:0] = cfg.gate[2];
      OFS_GATE4: next_prdata[GATE_WIDTH-1:0] = cfg.gate[3];
      OFS_CTRL:
      begin
        next_prdata[CTRL_FUNC_LSB +: 2] = cfg.func;
        next_prdata[CTRL_POL_BIT] = cfg.invert;
        next_prdata[CTRL_EN_BIT] = cfg.enable;
      end
      OFS_STATUS:
      begin
        next_prdata[STAT_DATA_LSB +: NUM_DATA] = data_in;
        next_prdata[STAT_GATE_LSB +: NUM_DATA] = gate_out;
        next_prdata[STAT_OUT_BIT] = cell_out;
      end
      default: next_prdata = 32'h00000000;
    endcase
  end

  // Captured at setup so the word stands still through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel && !penable && !pwrite && mapped)
    begin
      prdata <= next_prdata;
    end
    else if (psel && !penable)
    begin
      prdata <= 32'h00000000;
    end
  end

  // Stage one: data selection
  always_comb
  begin
    for (int i = 0; i < NUM_DATA; i++)
    begin
      next_data[i] = pick(cand_sync, cfg.sel[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_in <= '0;
    end
    else
    begin
      data_in <= next_data;
    end
  end

  // Stage two: data gating
  always_comb
  begin
    for (int i = 0; i < NUM_DATA; i++)
    begin
      next_gate[i] = gate_or(data_in, cfg.gate[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_out <= '0;
    end
    else
    begin
      gate_out <= next_gate;
    end
  end

  // Stages three and four: function then polarity
  always_comb
  begin
    next_out = (combine(gate_out, cfg.func) ^ cfg.invert) & cfg.enable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_out <= 1'b0;
    end
    else
    begin
      cell_out <= next_out;
    end
  end

endmodule // logic_cell

// File: dv/logic_cell_asserts.sv
// Purpose: Port checks of logic_cell
// Assumes: Zero-wait APB
// Notes: Gate regs are written before any quiet window
`timescale 1ns/1ns
module logic_cell_chk
  import logic_cell_pkg::*;
#(
  parameter int unsigned CANDIDATES = NUM_CANDIDATES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CANDIDATES-1:0] candidates,
  input wire logic [NUM_DATA-1:0] data_in,
  input wire logic [NUM_DATA-1:0] gate_out,
  input wire logic cell_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Slots 36/37 left out: the source toggles them
  sequence s_quiet_in;
    ($stable({candidates[39:38], candidates[35:0]}) && !psel)[*5];
  endsequence
  sequence s_quiet_data;
    ($stable(data_in) && !psel)[*3];
  endsequence
  sequence s_quiet_gate;
    ($stable(gate_out) && !psel)[*3];
  endsequence
  property p_ready_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no ready");
  property p_ready_pulse;
    pready |-> $past(psel) && !$past(penable) ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("bad ready");
  property p_err_map;
    psel && penable && pready |->
      pslverr == (paddr[31:8] != 0 || paddr[1:0] != 0 || paddr[7:0] > OFS_STATUS);
  endproperty
  a_err_map: assert property (p_err_map) else $error("bad error flag");
  property p_reset_out;
    $rose(presetn) |-> !pready && data_in == 0 && gate_out == 0 && !cell_out;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("bad reset");
  property p_status;
    psel && penable && pready && !pwrite && paddr == 32'(OFS_STATUS) |->
      prdata == {23'h0, $past(cell_out), $past(gate_out), $past(data_in)};
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_data_settle;
    s_quiet_in |-> $stable(data_in);
  endproperty
  a_data_settle: assert property (p_data_settle) else $error("data moved");
  property p_gate_settle;
    s_quiet_data |-> $stable(gate_out);
  endproperty
  a_gate_settle: assert property (p_gate_settle) else $error("gate moved");
  property p_out_settle;
    s_quiet_gate |-> $stable(cell_out);
  endproperty
  a_out_settle: assert property (p_out_settle) else $error("out moved");
endmodule // logic_cell_chk

bind logic_cell logic_cell_chk #(.CANDIDATES(CANDIDATES)) chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .candidates,
  .data_in, .gate_out, .cell_out);

// File: dv/cand_src.sv
// Purpose: Source of the forty candidates
// Assumes: Levels come from the bench
// Notes: Reserved slots toggle so a leak shows
`timescale 1ns/1ns
module cand_src
(
  input wire logic pclk,
  input wire logic [39:0] level,
  output logic [39:0] candidates
);
  logic tog = 1'b0;
  always @(posedge pclk)
  begin
    tog <= ~tog;
  end
  assign candidates = {level[39:38], {2{tog}}, level[35:0]};
endmodule // cand_src

// File: dv/tb.sv
// Purpose: Self-checking bench for logic_cell
// Assumes: Zero-wait APB at 100 MHz
// Notes: Gate regs written first; they have no reset
`timescale 1ns/1ns
module tb
  import logic_cell_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cell_out, e;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [3:0] pstrb, data_in, gate_out;
  logic [39:0] lvl, cand;
  int mismatches = 0, num_checks = 0, cyc = 0, ctl = 0;
  int sel[4] = '{default: 0};
  int gat[4];
  cand_src src (.pclk, .level(lvl), .candidates(cand));
  logic_cell DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .candidates(cand), .data_in, .gate_out, .cell_out);
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task automatic summarize();
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize();
    end
  end
  task automatic cmp_reg(logic [31:0] g, logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_path(logic [8:0] g, logic [8:0] x);
    num_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] v);
    apb(1, a, v);
    if (a < OFS_GATE1)
      sel[a[3:2]] = v[5:0];
    else if (a < OFS_CTRL)
      gat[a[3:2]] = v[7:0];
    else
      ctl = v & 32'h93;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] x, logic xe);
    apb(0, a, 0);
    cmp_reg(r, x);
    cmp_reg({31'h0, e}, {31'h0, xe});
  endtask
  function automatic logic [31:0] regval(logic [31:0] a);
    if (a < OFS_GATE1)
      return sel[a[3:2]];
    if (a < OFS_CTRL)
      return gat[a[3:2]];
    return ctl;
  endfunction
  function automatic logic [8:0] model(logic [39:0] c);
    logic [3:0] d;
    logic [3:0] g;
    logic f;
    for (int i = 0; i < 4; i++)
    begin
      d[i] = (sel[i] < 40 && sel[i] != 36 && sel[i] != 37) ? c[sel[i]] : 1'b0;
      g[i] = 1'b0;
    end
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 4; j++)
        g[i] |= (gat[i][2*j+1] & d[j]) | (gat[i][2*j] & ~d[j]);
    case (ctl[1:0])
      2'h0: f = (g[0] & g[1]) | (g[2] & g[3]);
      2'h1: f = (g[0] | g[1]) ^ (g[2] | g[3]);
      2'h2: f = &g;
      default: f = |g;
    endcase
    return {ctl[7] & (f ^ ctl[4]), g, d};
  endfunction
  task automatic check_path();
    repeat (7) @(posedge pclk);
    cmp_path({cell_out, gate_out, data_in}, model(lvl));
    apb(0, 32'(OFS_STATUS), 0);
    cmp_path(r[8:0], model(lvl));
  endtask
  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'hF;
    lvl = 0;
    void'($urandom(65050));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 4; i++)
      wr(32'(OFS_GATE1) + 4 * i, $urandom);
    for (int a = 0; a <= 32; a += 4)
    begin
      wr(a, $urandom);
      rd(a, regval(a), 1'b0);
    end
    rd(32'h28, 32'h0, 1'b1);
    rd(32'h2, 32'h0, 1'b1);
    pstrb <= 4'hE;
    apb(1, 32'(OFS_SEL0), 32'h3F);
    pstrb <= 4'hF;
    rd(32'(OFS_SEL0), regval(0), 1'b0);
    for (int k = 0; k < 64; k++)
    begin
      wr(32'(OFS_SEL0), k);
      for (int i = 1; i < 4; i++)
        wr(4 * i, $urandom_range(0, 63));
      lvl <= {8'($urandom), $urandom};
      check_path();
    end
    for (int n = 0; n < 32; n++)
    begin
      for (int i = 0; i < 4; i++)
        wr(32'(OFS_GATE1) + 4 * i, n == 5 ? 32'h0 : $urandom);
      wr(32'(OFS_CTRL), {n[3], 2'h0, n[2], 2'h0, n[1:0]});
      lvl <= {8'($urandom), $urandom};
      check_path();
    end
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    sel = '{default: 0};
    ctl = 0;
    for (int a = 0; a <= 32; a += 4)
      rd(a, regval(a), 1'b0);
    summarize();
  end
endmodule // tb
